// [dv/actuator_model.sv]
`timescale 1ns/10ps
// Bus actuators: each follows its value object on every telegram
module actuator_model (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// Telegrams
	input  wire seq_pkg::seq_out_t tel,
	// Actuator states
	output logic [4:0]             lamp,
	output logic [7:0]             count_seen
);
	import seq_pkg::*;
	// Shared count object keeps several inputs in step
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lamp       <= 5'h00;
			count_seen <= 8'h00;
		end else if (tel.send) begin
			lamp       <= tel.values;
			count_seen <= tel.operation_count;
		end
	end
endmodule

// [dv/switch_sequencer_props.sv]
`timescale 1ns/10ps
// Sequencer checks, seen from the top ports only
module switch_sequencer_props (
	// Clock and reset
	input wire logic               mclk,
	input wire logic               sys_rst,
	// Observed ports
	input wire seq_pkg::seq_cfg_t  cfg,
	input wire seq_pkg::step_req_t step_req,
	input wire logic               count_wr,
	input wire seq_pkg::seq_out_t  seq_out
);
	import seq_pkg::*;
	// Count, level count, mirrored count for the up-down pattern
	wire [7:0] k   = seq_out.operation_count;
	wire [7:0] n   = {5'h00, cfg.levels};
	wire [7:0] mir = (k <= n) ? k : (n + n - k);
	wire [4:0] one = k[0] ? (5'h01 << k[7:1]) : 5'h00;
	wire       snd = seq_out.send;
	wire       up1 = step_req.wr && !count_wr;  // A count write wins over a step
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_wr_send;
		count_wr |=> snd;
	endproperty
	a_wr_send: assert property (p_wr_send) else $error("no telegram after write");
	property p_levels;
		snd |-> (seq_out.values >> cfg.levels) == 5'h00;
	endproperty
	a_levels: assert property (p_levels) else $error("unused value object set");
	property p_stair;
		snd && (cfg.pattern == PAT_STAIR_STOP || cfg.pattern == PAT_STAIR_WRAP)
			|-> seq_out.values == ~(5'h1f << k);
	endproperty
	a_stair: assert property (p_stair) else $error("fill pattern wrong");
	property p_gray;
		snd && cfg.pattern == PAT_GRAY |-> seq_out.values == (k[4:0] ^ k[5:1]);
	endproperty
	a_gray: assert property (p_gray) else $error("gray pattern wrong");
	property p_updown;
		snd && cfg.pattern == PAT_UP_DOWN |-> seq_out.values == ~(5'h1f << mir);
	endproperty
	a_updown: assert property (p_updown) else $error("up-down pattern wrong");
	property p_single;
		snd && cfg.pattern == PAT_SINGLE |-> seq_out.values == one;
	endproperty
	a_single: assert property (p_single) else $error("single pattern wrong");
	property p_wrap_top;
		up1 && step_req.up && cfg.pattern == PAT_STAIR_WRAP && k == n |=> snd && k == 8'h00;
	endproperty
	a_wrap_top: assert property (p_wrap_top) else $error("no wrap to off");
	property p_stop_top;
		up1 && step_req.up && cfg.pattern == PAT_STAIR_STOP && k == n |=> !snd && $stable(k);
	endproperty
	a_stop_top: assert property (p_stop_top) else $error("step past end taken");
	property p_step_down;
		up1 && !step_req.up && k != 8'h00 |=> snd && k == $past(k) - 8'h01;
	endproperty
	a_step_down: assert property (p_step_down) else $error("down step wrong");
endmodule

bind switch_sequencer switch_sequencer_props props_i (.mclk(mclk), .sys_rst(sys_rst),
	.cfg(cfg), .step_req(step_req), .count_wr(count_wr), .seq_out(seq_out));

// [dv/switch_sequencer_tb_top.sv]
`timescale 1ns/10ps
module switch_sequencer_tb_top;
	import seq_pkg::*;
	logic       mclk, sys_rst, block_in, count_wr, manual_act, contact_in, mst_busy;
	logic [7:0] count_wr_data, count_seen;
	logic [4:0] lamp;
	seq_cfg_t   cfg;
	step_req_t  step_req;
	seq_out_t   seq_out;
	pattern_t   pat;
	int         n_fail, compares, c, n, top;

	switch_sequencer uut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .block_in(block_in),
		.step_req(step_req), .count_wr(count_wr), .count_wr_data(count_wr_data),
		.manual_act(manual_act), .contact_in(contact_in), .seq_out(seq_out),
		.mst_busy(mst_busy));
	actuator_model far (.mclk(mclk), .sys_rst(sys_rst), .tel(seq_out), .lamp(lamp),
		.count_seen(count_seen));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Expected value objects for count k under the current pattern
	function automatic logic [4:0] vals(input int k);
		case (pat)
			PAT_GRAY:    return 5'(k ^ (k >> 1));
			PAT_UP_DOWN: return ~(5'h1f << ((k <= n) ? k : 2 * n - k));
			PAT_SINGLE:  return k[0] ? 5'(1 << (k / 2)) : 5'h00;
			default:     return ~(5'h1f << k);
		endcase
	endfunction

	// Kind 0 step, 1 manual press, 2 count write; answer one edge later
	task automatic req(input int kind, input logic up, input logic [7:0] d);
		int e;
		if (kind == 2) e = (d > top) ? top : d;
		else if (up) e = (c < top) ? c + 1 : ((pat == PAT_STAIR_STOP) ? c : 0);
		else e = (c > 0) ? c - 1 : ((pat == PAT_STAIR_STOP) ? 0 : top);
		@(posedge mclk);
		step_req      <= '{kind == 0, up};
		manual_act    <= (kind == 1);
		count_wr      <= (kind == 2);
		count_wr_data <= d;
		@(posedge mclk);
		step_req.wr <= 1'b0;
		manual_act  <= 1'b0;
		count_wr    <= 1'b0;
		#1;
		chk(seq_out.send, (kind == 2) || (e != c));
		chk(seq_out.operation_count, 8'(e));
		chk(seq_out.values, vals(e));
		c = e;
	endtask

	// Watchdog: the run needs a few hundred cycles
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end

	initial begin
		n_fail = 0;
		compares = 0;
		c = 0;
		sys_rst = 1'b1;
		block_in = 1'b0;
		count_wr = 1'b0;
		manual_act = 1'b0;
		contact_in = 1'b0;
		count_wr_data = 8'h00;
		step_req = '0;
		cfg = '{2'h0, DEB_10, 1'b0, 1'b0, 16'h000a, 16'h000a, 3'h3, PAT_STAIR_STOP, 1'b0};
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		chk(seq_out.operation_count, 8'h00);
		chk(seq_out.values, 5'h00);
		chk(mst_busy, 1'b0);
		// Every pattern at every level count, through both ends
		for (int p = 0; p < 5; p++) begin
			for (n = 2; n <= 5; n++) begin
				pat = pattern_t'(p);
				top = (p == 1) ? (1 << n) - 1 : (p == 2 || p == 4) ? 2 * n - 1 : n;
				@(posedge mclk);
				cfg.pattern <= pat;
				cfg.levels  <= 3'(n);
				req(2, 1'b1, 8'h00);
				req(0, 1'b0, 8'h00);
				repeat (top + 1) req(0, 1'b1, 8'h00);
				req(0, 1'b0, 8'h00);
				req(2, 1'b1, 8'hff);
				@(posedge mclk);
				#1;
				chk(lamp, vals(c));
				chk(count_seen, 8'(c));
			end
		end
		// Manual presses in both directions while the input is blocked
		@(posedge mclk);
		block_in <= 1'b1;
		for (int d = 0; d < 2; d++) begin
			@(posedge mclk);
			cfg.dir_down <= d[0];
			req(1, !d[0], 8'h00);
		end
		// Reset in mid-run returns count, values and actuators to zero
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		chk(seq_out.operation_count, 8'h00);
		chk(seq_out.values, 5'h00);
		chk(lamp, 5'h00);
		chk(mst_busy, 1'b0);
		c = 0;
		req(0, 1'b1, 8'h00);
		stop_test();
	end
endmodule

// [src/input_conditioner.sv]
`timescale 1ns/10ps
`include "seq_defines.svh"

// Screening filter, polarity, debounce and minimum signal time
module input_conditioner (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             tick_ms,
	input  wire logic             tick_deci,
	// Configuration and control
	input  wire seq_pkg::seq_cfg_t cfg,
	input  wire logic             block_in,
	// Contact
	input  wire logic             contact_in,
	// Result
	output logic                  actuation,
	output logic                  mst_running
);
	import seq_pkg::*;

	logic       filt_reg;
	logic [3:0] scr_cnt_reg;
	logic [7:0] deb_cnt_reg;
	logic [15:0] mst_cnt_reg;
	logic       mst_act_reg;
	logic       mst_reg;

	// Screening length grows with the setting: more stable, slower
	wire [3:0] scr_len = (cfg.screening == 2'd0) ? `SCR_10NF_MS :
	                     (cfg.screening == 2'd1) ? `SCR_20NF_MS :
	                     (cfg.screening == 2'd2) ? `SCR_30NF_MS : `SCR_40NF_MS;

	// Debounce length in ms
	wire [7:0] deb_len = (cfg.debounce == DEB_10)  ? `DEB_10_MS  :
	                     (cfg.debounce == DEB_20)  ? `DEB_20_MS  :
	                     (cfg.debounce == DEB_30)  ? `DEB_30_MS  :
	                     (cfg.debounce == DEB_50)  ? `DEB_50_MS  :
	                     (cfg.debounce == DEB_70)  ? `DEB_70_MS  :
	                     (cfg.debounce == DEB_100) ? `DEB_100_MS : `DEB_150_MS;

	// Blocked input holds its last level, so no edges appear
	wire raw     = block_in ? filt_reg : contact_in;
	wire settled = (deb_cnt_reg == 8'h0);
	// Edge on the filtered level, only looked at outside debounce
	// Level must still differ when accepted: a level that falls back must not fire
	wire edge_v  = settled && (raw != filt_reg) && (scr_cnt_reg == scr_len);
	wire new_lvl = ~filt_reg;
	// Rising is normally open, falling normally closed
	wire is_act  = cfg.contact_open ? ~new_lvl : new_lvl;
	wire [15:0] mst_len = new_lvl ? cfg.min_sig_rise : cfg.min_sig_fall;

	// Screening: level must differ for scr_len ms before accepted
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			scr_cnt_reg <= 4'h0;
			filt_reg    <= 1'b0;
		end else if (raw == filt_reg || !settled) begin
			scr_cnt_reg <= 4'h0;
		end else if (edge_v) begin
			filt_reg    <= new_lvl;
			scr_cnt_reg <= 4'h0;
		end else if (tick_ms) begin
			scr_cnt_reg <= scr_cnt_reg + 4'h1;
		end
	end

	// Debounce starts with the accepted edge
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			deb_cnt_reg <= 8'h0;
		else if (edge_v)
			deb_cnt_reg <= deb_len;
		else if (tick_ms && !settled)
			deb_cnt_reg <= deb_cnt_reg - 8'h1;
	end

	// Minimum signal time: every edge restarts, expiry validates
	// Blocking suspends the wait, matching a frozen input
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mst_reg     <= 1'b0;
			mst_cnt_reg <= 16'h0;
			mst_act_reg <= 1'b0;
		end else if (edge_v && cfg.min_sig_en) begin
			mst_reg     <= 1'b1;
			mst_cnt_reg <= mst_len;
			mst_act_reg <= is_act;
		end else if (mst_reg && tick_deci && !block_in) begin
			if (mst_cnt_reg <= 16'h1)
				mst_reg <= 1'b0;
			mst_cnt_reg <= mst_cnt_reg - 16'h1;
		end
	end

	wire mst_done = mst_reg && tick_deci && !block_in && (mst_cnt_reg <= 16'h1);

	// Immediate response without minimum time, deferred with it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			actuation   <= 1'b0;
			mst_running <= 1'b0;
		end else begin
			actuation   <= cfg.min_sig_en ? (mst_done && mst_act_reg && !edge_v)
			                              : (edge_v && is_act);
			mst_running <= mst_reg;
		end
	end

endmodule

// [src/seq_defines.svh]
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// Clock and time base
`define CLK_MHZ          125
`define MS_TICK_NS       1000000
`define MS_TICK_CYCLES   (`MS_TICK_NS / (1000 / `CLK_MHZ))
`define DECI_TICK_MS     100

// Debounce times in ms
`define DEB_10_MS        8'd10
`define DEB_20_MS        8'd20
`define DEB_30_MS        8'd30
`define DEB_50_MS        8'd50
`define DEB_70_MS        8'd70
`define DEB_100_MS       8'd100
`define DEB_150_MS       8'd150

// Screening filter lengths in ms, one per setting
`define SCR_10NF_MS      4'd1
`define SCR_20NF_MS      4'd2
`define SCR_30NF_MS      4'd4
`define SCR_40NF_MS      4'd8

// Minimum signal time default in 0.1 s units
`define MIN_SIG_DEFAULT  16'd10

// Sequence lengths
`define LEVELS_MAX       3'd5
`define LEVELS_MIN       3'd2

`endif

// [src/seq_pkg.sv]
package seq_pkg;

	// Pattern selection
	typedef enum logic [2:0] {
		PAT_STAIR_STOP = 3'b000,
		PAT_GRAY       = 3'b001,
		PAT_UP_DOWN    = 3'b010,
		PAT_STAIR_WRAP = 3'b011,
		PAT_SINGLE     = 3'b100
	} pattern_t;

	// Debounce selection
	typedef enum logic [2:0] {
		DEB_10  = 3'b000,
		DEB_20  = 3'b001,
		DEB_30  = 3'b010,
		DEB_50  = 3'b011,
		DEB_70  = 3'b100,
		DEB_100 = 3'b101,
		DEB_150 = 3'b110
	} debounce_t;

	// Static configuration of one input
	typedef struct packed {
		logic [1:0]  screening;
		debounce_t   debounce;
		logic        contact_open;
		logic        min_sig_en;
		logic [15:0] min_sig_rise;
		logic [15:0] min_sig_fall;
		logic [2:0]  levels;
		pattern_t    pattern;
		logic        dir_down;
	} seq_cfg_t;

	// Externally written step request
	typedef struct packed {
		logic wr;
		logic up;
	} step_req_t;

	// Output telegram
	typedef struct packed {
		logic       send;
		logic [7:0] operation_count;
		logic [4:0] values;
	} seq_out_t;

endpackage

// [src/switch_sequencer.sv]
`timescale 1ns/10ps
`include "seq_defines.svh"

// Overview of operation
// - Four screening settings; higher slows evaluation
// - Respond immediately to edge, start debounce
// - Ignore input during selectable debounce interval
// - Contact type selects closing or opening actuation
// - Separate rise/fall minimum times, 0.1 s units
// - Rising is normally open, falling normally closed
// - Minimum time: edge starts interval, no telegram
// - Edge during minimum interval restarts it
// - Interval expiry emits validated telegram
// - Level count enables values from value 1
// - One bit per value, lowest is value 1
// - Each actuation advances at most one step; none at the pattern 1 ends
// - Pattern 1 fills up, stops at ends
// - Pattern 2 Gray code, wraps to off
// - Pattern 3 fills up then drains back
// - Pattern 4 fills up then all off
// - Pattern 5 single object on then off
// - External increment/decrement steps the sequence
// - Values derive only from operation count, pattern and level count
// - Direction setting picks up or down
// - Block disconnects input; manual still works

module switch_sequencer (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// Configuration
	input  wire seq_pkg::seq_cfg_t cfg,
	// Control objects
	input  wire logic              block_in,
	input  wire seq_pkg::step_req_t step_req,
	input  wire logic              count_wr,
	input  wire logic [7:0]        count_wr_data,
	input  wire logic              manual_act,
	// Contact
	input  wire logic              contact_in,
	// Value objects and count
	output seq_pkg::seq_out_t      seq_out,
	output logic                   mst_busy
);
	import seq_pkg::*;

	// ****************************************************************
	// Time base and conditioning
	// ****************************************************************

	logic tick_ms;
	logic tick_deci;
	logic local_act;
	logic mst_running;

	time_base u_time (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.tick_ms   (tick_ms),
		.tick_deci (tick_deci)
	);

	input_conditioner u_cond (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.tick_ms     (tick_ms),
		.tick_deci   (tick_deci),
		.cfg         (cfg),
		.block_in    (block_in),
		.contact_in  (contact_in),
		.actuation   (local_act),
		.mst_running (mst_running)
	);

	// ****************************************************************
	// Sequence length and pattern decode
	// ****************************************************************

	// Clamp the level setting into two to five
	wire [2:0] lv = (cfg.levels < `LEVELS_MIN) ? `LEVELS_MIN :
	                (cfg.levels > `LEVELS_MAX) ? `LEVELS_MAX : cfg.levels;

	// Highest count for a pattern: the count runs 0..top
	function automatic [7:0] top_count(input pattern_t p, input logic [2:0] n);
		logic [7:0] nn;
		nn = {5'h0, n};
		case (p)
			PAT_GRAY:    top_count = (8'h1 << n) - 8'h1;
			PAT_UP_DOWN: top_count = 8'(2 * nn - 1);
			PAT_SINGLE:  top_count = 8'(2 * nn - 1);
			default:     top_count = nn;
		endcase
	endfunction

	// Thermometer of k ones in the low bits
	function automatic [4:0] thermo(input logic [7:0] k);
		thermo = (k >= 8'd5) ? 5'h1f : 5'((8'h1 << k) - 8'h1);
	endfunction

	// Values are a pure function of the count, pattern and level count
	function automatic [4:0] decode(input pattern_t p, input logic [2:0] n,
	                                input logic [7:0] c);
		logic [7:0] g;
		g = c ^ (c >> 1);
		case (p)
			PAT_GRAY:    decode = g[4:0];
			PAT_UP_DOWN: decode = (c <= {5'h0, n}) ? thermo(c)
			                      : thermo(8'(2 * {5'h0, n}) - c);
			PAT_SINGLE:  decode = c[0] ? 5'(8'h1 << (c >> 1)) : 5'h0;
			default:     decode = thermo(c);
		endcase
	endfunction

	wire [7:0] top = top_count(cfg.pattern, lv);
	// Pattern 1 stops at the ends, the others wrap around
	wire       stops = (cfg.pattern == PAT_STAIR_STOP);

	// ****************************************************************
	// Step requests
	// ****************************************************************

	// Local and manual actuations use the direction setting
	wire loc_step = local_act || manual_act;
	// Both sources share one count; external wins a same-cycle clash
	wire do_step  = step_req.wr || loc_step;
	wire step_up  = step_req.wr ? step_req.up : !cfg.dir_down;

	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       send_next;

	// One step per request, bounded or wrapping
	always_comb begin
		count_next = count_reg;
		send_next  = 1'b0;
		if (count_wr) begin
			// Shared count object keeps several inputs aligned
			count_next = (count_wr_data > top) ? top : count_wr_data;
			send_next  = 1'b1;
		end else if (do_step) begin
			if (step_up) begin
				if (count_reg < top) begin
					count_next = count_reg + 8'h1;
					send_next  = 1'b1;
				end else if (!stops) begin
					count_next = 8'h0;
					send_next  = 1'b1;
				end
			end else begin
				if (count_reg != 8'h0) begin
					count_next = count_reg - 8'h1;
					send_next  = 1'b1;
				end else if (!stops) begin
					count_next = top;
					send_next  = 1'b1;
				end
			end
		end else if (count_reg > top) begin
			// Configuration shrank the sequence under us
			count_next = top;
		end
	end

	// ****************************************************************
	// State and outputs
	// ****************************************************************

	// One enable per value object; objects above the level count stay off
	wire [4:0] obj_en;

	for (genvar i = 0; i < 5; i++) begin : g_obj_en
		assign obj_en[i] = (3'(i) < lv);
	end

	// Values masked to the enabled objects
	wire [4:0] val_next = decode(cfg.pattern, lv, count_next) & obj_en;

	// Reset returns count and values to zero
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 8'h0;
			seq_out   <= '0;
			mst_busy  <= 1'b0;
		end else begin
			count_reg               <= count_next;
			seq_out.send            <= send_next;
			seq_out.operation_count <= count_next;
			seq_out.values          <= val_next;
			mst_busy                <= mst_running;
		end
	end

endmodule

// [src/time_base.sv]
`timescale 1ns/10ps
`include "seq_defines.svh"

// Free-running 1 ms and 0.1 s tick generator
module time_base (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Ticks
	output logic      tick_ms,
	output logic      tick_deci
);

	localparam int MS_CYC = `MS_TICK_CYCLES;

	logic [16:0] cyc_reg;
	logic [6:0]  ms_reg;

	wire cyc_wrap = (cyc_reg == 17'(MS_CYC - 1));
	wire ms_wrap  = (ms_reg == 7'(`DECI_TICK_MS - 1));

	// The ms counter advances only on the cycle wrap, so each 0.1 s tick falls on a 1 ms tick
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc_reg   <= 17'h0;
			ms_reg    <= 7'h0;
			tick_ms   <= 1'b0;
			tick_deci <= 1'b0;
		end else begin
			cyc_reg   <= cyc_wrap ? 17'h0 : cyc_reg + 17'h1;
			tick_ms   <= cyc_wrap;
			tick_deci <= cyc_wrap && ms_wrap;
			if (cyc_wrap)
				ms_reg <= ms_wrap ? 7'h0 : ms_reg + 7'h1;
		end
	end

endmodule
